// file: verilog/irq_router.sv
// peripheral interrupt router with ahb-lite register slave
`timescale 1ns/100ps
`include "irq_router_defines.svh"
module irq_router (
   input  wire  logic                       MCLK,
   input  wire  logic                       NRST,
   input  wire  logic                       HSEL,
   input  wire  logic [31:0]                HADDR,
   input  wire  logic [1:0]                 HTRANS,
   input  wire  logic                       HWRITE,
   input  wire  logic [2:0]                 HSIZE,
   input  wire  logic [31:0]                HWDATA,
   input  wire  logic                       HREADY,
   output logic       [31:0]                HRDATA,
   output logic                             HREADYOUT,
   output logic                             HRESP,
   input  wire  irq_router_pkg::slot_vec_t  PERIPH_IRQ,
   output irq_router_pkg::slot_vec_t        SLOT_IRQ,
   output logic                             IRQ,
   output irq_router_pkg::vec_addr_t        VECTOR_ADDR,
   output logic                             VECTOR_VALID
);
   import irq_router_pkg::*;

   slot_code_t  slot_sel [0:`SLOT_COUNT-1];
   slot_vec_t   routed;
   slot_vec_t   status;
   slot_vec_t   slot_en;
   logic [31:0] route_word [0:`ROUTE_WORDS-1];
   logic        wr_pend;
   word_idx_t   wr_idx;
   word_idx_t   addr_idx;
   logic        addr_take;
   logic [31:0] next_rdata;
   logic [31:0] fwd_word;
   logic        best_valid;
   logic [4:0]  best_slot;
   logic        first_cyc;

   assign addr_idx  = HADDR[15:2];
   assign addr_take = HSEL && HTRANS[1] && HREADY;

   genvar g;
   generate
      for (g = 0; g < `SLOT_COUNT; g++) begin : g_slot
         slot_mux u_mux (
            .sel    (slot_sel[g]),
            .req    (PERIPH_IRQ),
            .routed (routed[g])
         );
      end
   endgenerate

   always_comb begin
      for (int w = 0; w < `ROUTE_WORDS; w++) begin
         route_word[w] = 32'h0;
      end
      for (int s = 0; s < `SLOT_COUNT; s++) begin
         route_word[s / `FIELDS_PER_WORD][(s % `FIELDS_PER_WORD) * `FIELD_W +: `FIELD_W] =
            slot_sel[s];
      end
   end

   // ahb address phase capture
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         wr_pend <= 1'b0;
         wr_idx  <= 14'h0;
      end else begin
         wr_pend <= addr_take && HWRITE;
         wr_idx  <= addr_idx;
      end
   end

   // zero wait state, always okay
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
      end else begin
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
      end
   end

   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         for (int s = 0; s < `SLOT_COUNT; s++) begin
            slot_sel[s] <= 5'(s);
         end
      end else if (wr_pend) begin
         for (int s = 0; s < `SLOT_COUNT; s++) begin
            if (wr_idx == `IDX_SEL0 + 14'(s / `FIELDS_PER_WORD)) begin
               slot_sel[s] <= HWDATA[(s % `FIELDS_PER_WORD) * `FIELD_W +: `FIELD_W];
            end
         end
      end
   end

   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         slot_en <= `RST_SLOT_EN;
      end else if (wr_pend && wr_idx == `IDX_MASK) begin
         slot_en <= HWDATA[18:0];
      end
   end

   // sticky pending, set beats write-one clear
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         status <= 19'h0;
      end else if (wr_pend && wr_idx == `IDX_STATUS) begin
         status <= (status & ~HWDATA[18:0]) | SLOT_IRQ;
      end else begin
         status <= status | SLOT_IRQ;
      end
   end

   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         SLOT_IRQ <= 19'h0;
      end else begin
         SLOT_IRQ <= routed;
      end
   end

   always_comb begin
      best_valid = 1'b0;
      best_slot  = 5'h0;
      for (int s = `SLOT_COUNT - 1; s >= 0; s--) begin
         if (status[s] && slot_en[s]) begin
            best_valid = 1'b1;
            best_slot  = 5'(s);
         end
      end
   end

   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         VECTOR_ADDR  <= `VEC_BASE;
         VECTOR_VALID <= 1'b0;
         IRQ          <= 1'b0;
      end else begin
         VECTOR_ADDR  <= `VEC_BASE + 7'(best_slot * `VEC_STEP);
         VECTOR_VALID <= best_valid;
         IRQ          <= |(status & slot_en);
      end
   end

   always_comb begin
      fwd_word   = 32'h0;
      next_rdata = 32'h0;
      case (addr_idx)
         `IDX_SEL0:   next_rdata = route_word[0];
         `IDX_SEL1:   next_rdata = route_word[1];
         `IDX_SEL2:   next_rdata = route_word[2];
         `IDX_SEL3:   next_rdata = route_word[3];
         `IDX_STATUS: next_rdata = {13'h0, status};
         `IDX_MASK:   next_rdata = {13'h0, slot_en};
         `IDX_VECT:   next_rdata = {23'h0, best_valid, 1'b0, VECTOR_ADDR};
         default:     next_rdata = 32'h0;
      endcase
      if (wr_pend && wr_idx == addr_idx) begin
         case (addr_idx)
            `IDX_SEL0, `IDX_SEL1, `IDX_SEL2: fwd_word = {2'b00, HWDATA[29:0]};
            `IDX_SEL3: fwd_word = {27'h0, HWDATA[4:0]};
            `IDX_MASK: fwd_word = {13'h0, HWDATA[18:0]};
            default:   fwd_word = next_rdata;
         endcase
         next_rdata = fwd_word;
      end
   end

   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         HRDATA <= 32'h0;
      end else if (addr_take && !HWRITE) begin
         HRDATA <= next_rdata;
      end
   end

   // marks first cycle after reset release
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         first_cyc <= 1'b1;
      end else begin
         first_cyc <= 1'b0;
      end
   end

   // ---------------- assertions ----------------
   logic rd_sel0;
   logic rd_sel1;
   logic rd_sel2;
   logic rd_sel3;
   assign rd_sel0 = addr_take && !HWRITE && addr_idx == `IDX_SEL0 && !wr_pend;
   assign rd_sel1 = addr_take && !HWRITE && addr_idx == `IDX_SEL1 && !wr_pend;
   assign rd_sel2 = addr_take && !HWRITE && addr_idx == `IDX_SEL2 && !wr_pend;
   assign rd_sel3 = addr_take && !HWRITE && addr_idx == `IDX_SEL3 && !wr_pend;

   property p_route;
      @(posedge MCLK) disable iff (!NRST)
      (slot_sel[2] <= `MAX_CODE && slot_sel[2] != `RSV_CODE_A &&
       slot_sel[2] != `RSV_CODE_B && slot_sel[2] != `RSV_CODE_C &&
       PERIPH_IRQ[slot_sel[2]]) |=> SLOT_IRQ[2];
   endproperty
   a_route: assert property (p_route)
      else $error("slot 2 missed its selected source");

   property p_pack0;
      @(posedge MCLK) disable iff (!NRST)
      rd_sel0 |=> (HRDATA[9:5] == $past(slot_sel[1])) &&
                  (HRDATA[29:25] == $past(slot_sel[5]));
   endproperty
   a_pack0: assert property (p_pack0)
      else $error("word 0 field layout wrong");

   property p_word0;
      @(posedge MCLK) disable iff (!NRST)
      rd_sel0 |=> HRDATA[4:0] == $past(slot_sel[0]) && HRDATA[31:30] == 2'b00;
   endproperty
   a_word0: assert property (p_word0)
      else $error("word 0 does not hold slot 0");

   property p_word1;
      @(posedge MCLK) disable iff (!NRST)
      rd_sel1 |=> HRDATA[4:0] == $past(slot_sel[6]) &&
                  HRDATA[29:25] == $past(slot_sel[11]);
   endproperty
   a_word1: assert property (p_word1)
      else $error("word 1 slot order wrong");

   property p_word2;
      @(posedge MCLK) disable iff (!NRST)
      rd_sel2 |=> HRDATA[4:0] == $past(slot_sel[12]) &&
                  HRDATA[29:25] == $past(slot_sel[17]);
   endproperty
   a_word2: assert property (p_word2)
      else $error("word 2 slot order wrong");

   property p_word3;
      @(posedge MCLK) disable iff (!NRST)
      rd_sel3 |=> HRDATA == {27'h0, $past(slot_sel[18])};
   endproperty
   a_word3: assert property (p_word3)
      else $error("word 3 holds more than slot 18");

   property p_vector;
      @(posedge MCLK) disable iff (!NRST)
      VECTOR_VALID |-> VECTOR_ADDR >= `VEC_BASE && VECTOR_ADDR <= `VEC_LAST &&
                       VECTOR_ADDR[1:0] == 2'b00;
   endproperty
   a_vector: assert property (p_vector)
      else $error("vector outside slot table");

   property p_prio;
      @(posedge MCLK) disable iff (!NRST)
      (status[0] && slot_en[0]) |=> VECTOR_VALID && VECTOR_ADDR == `VEC_BASE;
   endproperty
   a_prio: assert property (p_prio)
      else $error("slot 0 did not win priority");

   property p_replace;
      @(posedge MCLK) disable iff (!NRST)
      (wr_pend && wr_idx == `IDX_SEL1) |=> slot_sel[6] == $past(HWDATA[4:0]);
   endproperty
   a_replace: assert property (p_replace)
      else $error("slot 6 source not replaced");

   property p_en_hold;
      @(posedge MCLK) disable iff (!NRST)
      !(wr_pend && wr_idx == `IDX_MASK) |=> $stable(slot_en);
   endproperty
   a_en_hold: assert property (p_en_hold)
      else $error("slot enables changed without a write");

   property p_reset_val;
      @(posedge MCLK) disable iff (!NRST)
      first_cyc |-> route_word[0] == `RST_SEL0 && route_word[1] == `RST_SEL1 &&
                    route_word[2] == `RST_SEL2 && route_word[3] == `RST_SEL3 &&
                    slot_en == `RST_SLOT_EN;
   endproperty
   a_reset_val: assert property (p_reset_val)
      else $error("routing words not at reset values");

   property p_reserved;
      @(posedge MCLK) disable iff (!NRST)
      (slot_sel[4] == `RSV_CODE_B) |=> !SLOT_IRQ[4];
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved source raised a slot");

   property p_wr_effect;
      @(posedge MCLK) disable iff (!NRST)
      (wr_pend && wr_idx == `IDX_SEL3 && HWDATA[4:0] == 5'h07 && PERIPH_IRQ[7])
         ##1 PERIPH_IRQ[7] |=> SLOT_IRQ[18];
   endproperty
   a_wr_effect: assert property (p_wr_effect)
      else $error("routing write not effective next cycle");

   c_reroute: cover property (@(posedge MCLK) disable iff (!NRST)
      wr_pend && wr_idx == `IDX_SEL0 ##1 SLOT_IRQ[0]);
   c_irq: cover property (@(posedge MCLK) disable iff (!NRST) $rose(IRQ));
   c_clear: cover property (@(posedge MCLK) disable iff (!NRST)
      wr_pend && wr_idx == `IDX_STATUS ##1 !IRQ);
endmodule : irq_router

// file: verilog/irq_router_defines.svh
// constants of the peripheral interrupt router
`ifndef IRQ_ROUTER_DEFINES_SVH
`define IRQ_ROUTER_DEFINES_SVH

`define SLOT_COUNT      19
`define FIELD_W         5
`define FIELDS_PER_WORD 6
`define ROUTE_WORDS     4

// register indices; byte address is four times the index
`define IDX_SEL0   14'h2200
`define IDX_SEL1   14'h2201
`define IDX_SEL2   14'h2202
`define IDX_SEL3   14'h2203
`define IDX_STATUS 14'h2204
`define IDX_MASK   14'h2205
`define IDX_VECT   14'h2206

`define RST_SEL0    32'h0a418820
`define RST_SEL1    32'h16a4a0e6
`define RST_SEL2    32'h2307b9ac
`define RST_SEL3    32'h00000012
`define RST_SLOT_EN 19'h00202

`define RSV_CODE_A 5'h0b
`define RSV_CODE_B 5'h0e
`define RSV_CODE_C 5'h10
`define MAX_CODE   5'h12

`define VEC_BASE 7'h2c
`define VEC_STEP 7'h04
`define VEC_LAST 7'h74

`endif

// file: verilog/irq_router_pkg.sv
// types shared by the peripheral interrupt router
package irq_router_pkg;
   typedef logic [4:0]  slot_code_t;
   typedef logic [18:0] slot_vec_t;
   typedef logic [13:0] word_idx_t;
   typedef logic [6:0]  vec_addr_t;
endpackage : irq_router_pkg

// file: verilog/slot_mux.sv
// one slot's source selector
`timescale 1ns/100ps
`include "irq_router_defines.svh"
module slot_mux (
   input  wire irq_router_pkg::slot_code_t sel,
   input  wire irq_router_pkg::slot_vec_t  req,
   output logic                            routed
);
   import irq_router_pkg::*;

   logic valid;

   always_comb begin
      valid = (sel <= `MAX_CODE) && (sel != `RSV_CODE_A) &&
              (sel != `RSV_CODE_B) && (sel != `RSV_CODE_C);
      routed = valid ? req[sel] : 1'b0;
   end
endmodule : slot_mux

// file: testbench/periph_core_model.sv
// peripheral request lines and core vector latch model
`timescale 1ns/100ps
module periph_core_model (
   input  wire logic                      clk,
   input  wire logic                      rst_n,
   input  wire irq_router_pkg::slot_vec_t want,
   input  wire logic                      slow,
   input  wire logic                      irq,
   input  wire irq_router_pkg::vec_addr_t vec,
   input  wire logic                      vec_ok,
   output irq_router_pkg::slot_vec_t      lines,
   output irq_router_pkg::vec_addr_t      latched
);
   import irq_router_pkg::*;
   slot_vec_t hold;
   // level sources, one or two edges late
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hold  <= '0;
         lines <= '0;
      end else begin
         hold  <= want;
         lines <= slow ? hold : want;
      end
   end
   // core takes the vector while request is up
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         latched <= 7'h00;
      else if (irq && vec_ok)
         latched <= vec;
   end
endmodule : periph_core_model

// file: testbench/tb.sv
// self-checking bench of the peripheral interrupt router
`timescale 1ns/100ps
`include "irq_router_defines.svh"
module tb;
   import irq_router_pkg::*;
   logic        mclk = 1'b0;
   logic        nrst = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = '0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = '0;
   logic        slow = 1'b0;
   slot_vec_t   want = '0;
   logic [31:0] hrdata, rd, rv;
   logic [31:0] w [4];
   logic        hreadyout, hresp, irq, vvalid;
   slot_vec_t   periph, slots;
   vec_addr_t   vaddr, latched, ev;
   integer      errors = 0;
   integer      total_checks = 0;
   integer      seed = 32'hbf16;

   always #4 mclk = ~mclk;

   irq_router u_dut (.MCLK(mclk), .NRST(nrst), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
      .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
      .PERIPH_IRQ(periph), .SLOT_IRQ(slots), .IRQ(irq), .VECTOR_ADDR(vaddr),
      .VECTOR_VALID(vvalid));

   periph_core_model u_far (.clk(mclk), .rst_n(nrst), .want(want), .slow(slow),
      .irq(irq), .vec(vaddr), .vec_ok(vvalid), .lines(periph), .latched(latched));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic bus(input logic wr, input word_idx_t i, input logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= {16'h0, i, 2'b00};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel   <= 1'b0;
      hwdata <= d;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      chk(hresp, 32'h0);
   endtask : bus

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask : tick

   function automatic slot_vec_t route(input slot_vec_t req);
      logic [4:0] c;
      route = '0;
      for (int k = 0; k < `SLOT_COUNT; k++) begin
         c = w[k / 6][(k % 6) * 5 +: 5];
         if (c <= `MAX_CODE && c != `RSV_CODE_A && c != `RSV_CODE_B && c != `RSV_CODE_C)
            route[k] = req[c];
      end
   endfunction : route

   function automatic vec_addr_t lowest(input slot_vec_t p, input int s);
      lowest = `VEC_BASE;
      for (int k = `SLOT_COUNT - 1; k >= s; k--)
         if (p[k])
            lowest = vec_addr_t'(`VEC_BASE + `VEC_STEP * k);
   endfunction : lowest

   task automatic summarize();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : summarize

   initial begin
      repeat (10) @(posedge mclk);
      nrst <= 1'b1;
      @(posedge mclk);
      w = '{`RST_SEL0, `RST_SEL1, `RST_SEL2, `RST_SEL3};
      for (int j = 0; j < 4; j++) begin
         bus(1'b0, word_idx_t'(`IDX_SEL0 + j), '0);
         chk(rd, w[j]);
      end
      bus(1'b0, `IDX_MASK, '0);
      chk(rd, {13'h0, `RST_SLOT_EN});
      bus(1'b0, 14'h0123, '0);
      chk(rd, 32'h0);
      for (int i = 0; i < 24; i++) begin
         if (i > 0)
            for (int j = 0; j < 4; j++) begin
               rv = (i == 1) ? 32'hffffffff : (i == 2) ? 32'h1ce739ce : $random(seed);
               bus(1'b1, word_idx_t'(`IDX_SEL0 + j), rv);
               w[j] = rv & ((j == 3) ? 32'h1f : 32'h3fffffff);
               bus(1'b0, word_idx_t'(`IDX_SEL0 + j), '0);
               chk(rd, w[j]);
            end
         want <= slot_vec_t'($random(seed));
         slow <= i[0];
         tick(4);
         chk(slots, route(want));
      end
      want <= 19'h00080;
      tick(4);
      w[3] = 32'h7;
      bus(1'b1, `IDX_SEL3, w[3]);
      tick(2);
      chk(slots, route(want));
      // stale pending bits cleared
      want <= '0;
      tick(4);
      bus(1'b1, `IDX_STATUS, 32'h7ffff);
      w = '{32'h0a41882c, `RST_SEL1, `RST_SEL2, `RST_SEL3};
      for (int j = 0; j < 4; j++)
         bus(1'b1, word_idx_t'(`IDX_SEL0 + j), w[j]);
      want <= '1;
      slow <= 1'b0;
      tick(4);
      for (int s = 0; s < `SLOT_COUNT; s++) begin
         bus(1'b1, `IDX_MASK, 32'h7ffff << s);
         tick(3);
         ev = lowest(route(want), s);
         chk(irq, 32'h1);
         chk(vvalid, 32'h1);
         chk(vaddr, ev);
         chk(latched, ev);
         bus(1'b0, `IDX_VECT, '0);
         chk(rd, {23'h0, 1'b1, 1'b0, ev});
      end
      bus(1'b1, `IDX_MASK, 32'h0);
      tick(3);
      chk(irq, 32'h0);
      chk(vvalid, 32'h0);
      want <= '0;
      tick(4);
      bus(1'b1, `IDX_STATUS, 32'h1);
      bus(1'b0, `IDX_STATUS, '0);
      chk(rd, route('1) & 19'h7fffe);
      bus(1'b1, `IDX_STATUS, 32'h7ffff);
      bus(1'b1, `IDX_MASK, 32'h7ffff);
      tick(3);
      chk(irq, 32'h0);
      summarize();
   end

   initial begin
      repeat (20000) @(posedge mclk);
      errors++;
      summarize();
   end
endmodule : tb
